// [hdl/dct_ctl_end.sv]
// Command issuer end: AHB-Lite registers, link clock divider and spacing checks.
// Assumes one AHB-Lite master, word transfers only, and ce high during bus traffic.
module dct_ctl_end #(
  parameter bit HIGH_GRADE = 1'b0,
  parameter int REFI_CYC = dct_pkg::TREFI_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  dct_link_if.ctl link
);
  localparam int EV_RD = 0;
  localparam int EV_WR = 1;
  localparam int EV_ACT = 2;
  localparam int EV_PRE = 3;
  localparam int EV_WRA = 4;
  localparam int EV_CKE = 5;
  localparam int EV_PDX = 6;
  localparam int NEV = 7;

  if (REFI_CYC < 2 || REFI_CYC > 2047) begin : g_chk
    $error("REFI_CYC out of range");
  end

  logic [15:0] mode, next_mode;
  logic odt_req, next_odt_req;
  logic [7:0] div_set, next_div_set, div_live, next_div_live, div_cnt, next_div_cnt;
  logic ck_q, next_ck, cke_q, next_cke, odt_q, next_odt;
  logic [2:0] cmd_q, next_cmd;
  logic [15:0] addr_q, next_addr;
  logic pend, next_pend, bank_open, next_bank_open, exit_apd, next_exit_apd;
  dct_pkg::dct_op_e op, next_op, last_op, next_last_op;
  dct_pkg::dct_pwr_e pwr, next_pwr;
  logic [7:0] since [NEV];
  logic [7:0] next_since [NEV];
  logic lost, next_lost, untrusted, next_untrusted;
  logic [10:0] refi_cnt, next_refi_cnt;
  logic ap_wr, next_ap_wr, ap_rd, next_ap_rd, next_hready;
  logic [7:0] ap_addr, next_ap_addr;
  logic [31:0] next_hrdata, rd_mux;
  logic wrap, rise, fall, ok, here, issue;
  logic loss_ev, taint_ev;
  logic [2:0] al;
  logic [7:0] rd_pre, rp_ck, ras_ck, rtp_ck, dal_ck, rd_gap, xp, wdiv;
  logic [3:0] wop;

  assign al = mode[dct_pkg::MR_AL_LSB +: 3];
  assign wrap = (div_cnt == div_live - 8'h01);
  assign rise = wrap & ~ck_q;
  assign fall = wrap & ck_q;
  assign rd_pre = {5'h00, al} + (mode[dct_pkg::MR_BL8] ? 8'h04 : 8'h02);
  // Analog times become cycle counts at the live link period, rounded up
  assign rp_ck = dct_pkg::ns_to_ck(dct_pkg::TRP_NS, div_live);
  assign ras_ck = dct_pkg::ns_to_ck(dct_pkg::ACT_TO_PRE_MIN_NS, div_live);
  assign rtp_ck = dct_pkg::ns_to_ck(dct_pkg::READ_TO_PRE_GAP_NS, div_live);
  assign dal_ck = {5'h00, mode[dct_pkg::MR_WR_LSB +: 3]} + 8'h01 + rp_ck;
  assign xp = HIGH_GRADE ? dct_pkg::XP_HI : dct_pkg::XP_LO;
  assign wop = hwdata[3:0];
  assign wdiv = hwdata[dct_pkg::CTRL_DIV_LSB +: 8];
  // Events that set the sticky flags; a clear in the same cycle loses
  assign loss_ev = pwr != dct_pkg::PS_SREF && refi_cnt == 11'(REFI_CYC - 1);
  assign taint_ev = issue && op == dct_pkg::OP_RD && lost;

  always_comb begin
    rd_gap = 8'h00;
    if (exit_apd) begin
      // Read delay after an active power-down exit tracks the exit mode
      rd_gap = mode[dct_pkg::MR_SLOW] ?
               (HIGH_GRADE ? dct_pkg::XARDS_HI : dct_pkg::XARDS_LO) - {5'h00, al} :
               dct_pkg::XARD_CK;
    end
    if (pwr == dct_pkg::PS_RUN) here = op != dct_pkg::OP_PDX && op != dct_pkg::OP_SRX;
    else if (pwr == dct_pkg::PS_SREF) here = op == dct_pkg::OP_SRX;
    else here = op == dct_pkg::OP_PDX;
    case (op)
      dct_pkg::OP_RD:
        ok = since[EV_WR] >= dct_pkg::WTR_CK && since[EV_PDX] >= rd_gap;
      dct_pkg::OP_PRE:
        ok = since[EV_RD] >= rd_pre && since[EV_RD] >= rtp_ck &&
             since[EV_ACT] >= ras_ck;
      dct_pkg::OP_ACT:
        ok = since[EV_PDX] >= xp && since[EV_PRE] >= rp_ck &&
             since[EV_WRA] >= dal_ck;
      dct_pkg::OP_PDE, dct_pkg::OP_SRE, dct_pkg::OP_PDX, dct_pkg::OP_SRX:
        ok = since[EV_CKE] >= dct_pkg::CKE_MIN_CK;
      default:
        ok = 1'b1;
    endcase
    issue = pend & here & ok & fall;
  end

  always_comb begin
    case (haddr[7:0])
      dct_pkg::REG_CMD: rd_mux = {28'h000_0000, last_op};
      dct_pkg::REG_MODE: rd_mux = {16'h0000, mode};
      dct_pkg::REG_CTRL: rd_mux = {16'h0000, div_set, 7'h00, odt_req};
      dct_pkg::REG_STATUS: rd_mux = {26'h000_0000, untrusted, lost, pend, pwr, cke_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_mode = mode;
    next_odt_req = odt_req;
    next_div_set = div_set;
    next_div_live = div_live;
    next_div_cnt = wrap ? 8'h00 : div_cnt + 8'h01;
    next_ck = wrap ? ~ck_q : ck_q;
    next_cke = cke_q;
    next_odt = odt_q;
    next_cmd = cmd_q;
    next_addr = addr_q;
    next_pend = pend;
    next_op = op;
    next_last_op = last_op;
    next_pwr = pwr;
    next_bank_open = bank_open;
    next_exit_apd = exit_apd;
    next_lost = lost;
    next_untrusted = untrusted;
    next_refi_cnt = refi_cnt;
    next_ap_wr = ap_wr;
    next_ap_rd = ap_rd;
    next_ap_addr = ap_addr;
    next_hrdata = hrdata;
    for (int i = 0; i < NEV; i++) begin
      next_since[i] = (rise && since[i] != 8'hFF) ? since[i] + 8'h01 : since[i];
    end
    if (pwr != dct_pkg::PS_SREF) begin
      if (refi_cnt == 11'(REFI_CYC - 1)) next_lost = 1'b1;
      else next_refi_cnt = refi_cnt + 11'h001;
    end
    // A new period is adopted only while the device ignores its clock
    if (wrap && (pwr == dct_pkg::PS_SREF || pwr == dct_pkg::PS_PPD)) next_div_live = div_set;
    if (fall) begin
      next_cmd = dct_pkg::LC_NOP;
      next_odt = odt_req;
      if (pend && !here) next_pend = 1'b0;
    end
    if (issue) begin
      next_pend = 1'b0;
      next_last_op = op;
      case (op)
        dct_pkg::OP_ACT: begin
          next_cmd = dct_pkg::LC_ACT;
          next_bank_open = 1'b1;
          next_since[EV_ACT] = 8'h00;
        end
        dct_pkg::OP_RD: begin
          next_cmd = dct_pkg::LC_RD;
          next_since[EV_RD] = 8'h00;
          if (lost) next_untrusted = 1'b1;
        end
        dct_pkg::OP_WR, dct_pkg::OP_WRA: begin
          next_cmd = op == dct_pkg::OP_WR ? dct_pkg::LC_WR : dct_pkg::LC_WRA;
          next_since[EV_WR] = 8'h00;
          if (op == dct_pkg::OP_WRA) begin
            next_since[EV_WRA] = 8'h00;
            next_bank_open = 1'b0;
          end
        end
        dct_pkg::OP_PRE: begin
          next_cmd = dct_pkg::LC_PRE;
          next_bank_open = 1'b0;
          next_since[EV_PRE] = 8'h00;
        end
        dct_pkg::OP_MRS: begin
          next_cmd = dct_pkg::LC_MRS;
          next_addr = mode;
        end
        dct_pkg::OP_REF: begin
          next_cmd = dct_pkg::LC_REF;
          next_refi_cnt = 11'h000;
        end
        dct_pkg::OP_PDE, dct_pkg::OP_SRE: begin
          next_cke = 1'b0;
          next_since[EV_CKE] = 8'h00;
          if (op == dct_pkg::OP_SRE) begin
            next_cmd = dct_pkg::LC_REF;
            next_pwr = dct_pkg::PS_SREF;
          end else begin
            next_pwr = bank_open ? dct_pkg::PS_APD : dct_pkg::PS_PPD;
          end
        end
        dct_pkg::OP_PDX, dct_pkg::OP_SRX: begin
          next_cke = 1'b1;
          next_since[EV_CKE] = 8'h00;
          next_since[EV_PDX] = 8'h00;
          next_exit_apd = pwr == dct_pkg::PS_APD;
          next_pwr = dct_pkg::PS_RUN;
          if (op == dct_pkg::OP_SRX) next_refi_cnt = 11'h000;
        end
        default: begin
        end
      endcase
    end
    if (ap_wr && hreadyout) begin
      case (ap_addr)
        dct_pkg::REG_CMD: begin
          next_pend = 1'b1;
          next_op = dct_pkg::dct_op_e'(wop);
        end
        dct_pkg::REG_MODE: next_mode = hwdata[15:0];
        dct_pkg::REG_CTRL: begin
          next_odt_req = hwdata[0];
          next_div_set = wdiv < dct_pkg::DIV_MIN ? dct_pkg::DIV_MIN : wdiv;
        end
        dct_pkg::REG_STATUS: begin
          // Software clears after rewriting data; a new loss wins over the clear
          if (hwdata[dct_pkg::ST_LOST] && !loss_ev) next_lost = 1'b0;
          if (hwdata[dct_pkg::ST_UNTRUSTED] && !taint_ev) next_untrusted = 1'b0;
        end
        default: begin
        end
      endcase
    end
    if (hreadyout) begin
      next_ap_wr = hsel & htrans[1] & hready & hwrite;
      next_ap_rd = hsel & htrans[1] & hready & ~hwrite;
      next_ap_addr = haddr[7:0];
      if (next_ap_rd) next_hrdata = rd_mux;
    end
    // A command write waits in its data phase until the previous one has left
    next_hready = !(next_ap_wr && next_ap_addr == dct_pkg::REG_CMD && next_pend);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= dct_pkg::MODE_RESET;
      odt_req <= 1'b0;
      div_set <= dct_pkg::DIV_RESET;
      div_live <= dct_pkg::DIV_RESET;
      div_cnt <= 8'h00;
      ck_q <= 1'b0;
      cke_q <= 1'b0;
      odt_q <= 1'b0;
      cmd_q <= dct_pkg::LC_NOP;
      addr_q <= 16'h0000;
      pend <= 1'b0;
      op <= dct_pkg::OP_NOP;
      last_op <= dct_pkg::OP_NOP;
      pwr <= dct_pkg::PS_PPD;
      bank_open <= 1'b0;
      exit_apd <= 1'b0;
      for (int i = 0; i < NEV; i++) since[i] <= 8'hFF;
      lost <= 1'b0;
      untrusted <= 1'b0;
      refi_cnt <= 11'h000;
      ap_wr <= 1'b0;
      ap_rd <= 1'b0;
      ap_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      mode <= next_mode;
      odt_req <= next_odt_req;
      div_set <= next_div_set;
      div_live <= next_div_live;
      div_cnt <= next_div_cnt;
      ck_q <= next_ck;
      cke_q <= next_cke;
      odt_q <= next_odt;
      cmd_q <= next_cmd;
      addr_q <= next_addr;
      pend <= next_pend;
      op <= next_op;
      last_op <= next_last_op;
      pwr <= next_pwr;
      bank_open <= next_bank_open;
      exit_apd <= next_exit_apd;
      for (int i = 0; i < NEV; i++) since[i] <= next_since[i];
      lost <= next_lost;
      untrusted <= next_untrusted;
      refi_cnt <= next_refi_cnt;
      ap_wr <= next_ap_wr;
      ap_rd <= next_ap_rd;
      ap_addr <= next_ap_addr;
      hrdata <= next_hrdata;
      hreadyout <= next_hready;
      hresp <= 1'b0;
    end
  end

  assign link.ck = ck_q;
  assign link.cke = cke_q;
  assign link.cmd = cmd_q;
  assign link.addr = addr_q;
  assign link.on_die_termination = odt_q;
endmodule

// [hdl/dct_link_if.sv]
// Link between the command issuer and the memory device.
// The issuer drives every signal; the device only samples them.
interface dct_link_if;
  logic ck;
  logic cke;
  logic [2:0] cmd;
  logic [15:0] addr;
  logic on_die_termination;
  modport ctl (output ck, output cke, output cmd, output addr, output on_die_termination);
  modport dev (input ck, input cke, input cmd, input addr, input on_die_termination);
endinterface

// [hdl/dct_mem_end.sv]
// Memory device end: registers link commands on synchronised ck rises.
// Assumes the ck half period is at least two hclk cycles.
// Operation
// - Precharge waits read gap, rtp and ras.
// - Hold clock gate for three registrations.
// - Read waits two cycles after write.
// - Mode bit picks fast or slow exit.
// - Read after exit waits two or slow count.
// - Termination on two edges after high.
// - Termination off half period after second fall.
// - Clock rate changes only while refreshing itself or in precharge power-down.
// - Nanosecond times round up to whole cycles.
// - Auto precharge recovery is recovery plus precharge.
// - Activate after exit waits two or three.
// - Lost refresh marks reads untrusted until rewritten.
// - Clear strobe bit means differential strobe.
// - Long write strobe tail is tolerated.
module dct_mem_end #(
  parameter bit HIGH_GRADE = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  dct_link_if.dev link,
  input wire logic err_clr,
  output logic term_on,
  output dct_pkg::dct_pwr_e pwr_state,
  output logic diff_strobe,
  output logic slow_exit,
  output logic timing_err,
  output logic cke_err
);
  logic [21:0] s1, s2;
  logic ck_d, rise, fall;
  logic cke_r, odt_r, bank_open, exit_apd, single_strobe, bl8;
  logic [2:0] al;
  logic [1:0] cke_run, on_cnt, off_falls;
  logic [7:0] per_cnt, per_len, off_wait, since_rd, since_wr, since_act, since_exit;
  logic next_cke_r, next_odt_r, next_bank_open, next_exit_apd, next_single_strobe, next_bl8;
  logic [2:0] next_al;
  logic [1:0] next_cke_run, next_on_cnt, next_off_falls;
  logic [7:0] next_per_cnt, next_per_len, next_off_wait;
  logic [7:0] next_since_rd, next_since_wr, next_since_act, next_since_exit;
  logic next_term_on, next_slow_exit, next_timing_err, next_cke_err;
  dct_pkg::dct_pwr_e next_pwr;
  logic s_ck, s_cke, s_odt;
  logic [2:0] s_cmd;
  logic [15:0] s_addr;
  logic [7:0] rd_gap, xp;

  // Every link input passes two flops; only the second is read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1 <= '0;
      s2 <= '0;
      ck_d <= 1'b0;
    end else if (ce) begin
      s1 <= {link.addr, link.cmd, link.on_die_termination, link.cke, link.ck};
      s2 <= s1;
      ck_d <= s2[0];
    end
  end

  assign {s_addr, s_cmd, s_odt, s_cke, s_ck} = s2;
  assign rise = ce & s_ck & ~ck_d;
  assign fall = ce & ~s_ck & ck_d;
  assign xp = HIGH_GRADE ? dct_pkg::XP_HI : dct_pkg::XP_LO;

  always_comb begin
    next_cke_r = cke_r;
    next_odt_r = odt_r;
    next_bank_open = bank_open;
    next_exit_apd = exit_apd;
    next_single_strobe = single_strobe;
    next_bl8 = bl8;
    next_al = al;
    next_cke_run = cke_run;
    next_on_cnt = on_cnt;
    next_off_falls = off_falls;
    next_per_cnt = per_cnt + 8'h01;
    next_per_len = per_len;
    next_off_wait = off_wait;
    next_since_rd = since_rd;
    next_since_wr = since_wr;
    next_since_act = since_act;
    next_since_exit = since_exit;
    next_term_on = term_on;
    next_slow_exit = slow_exit;
    next_pwr = pwr_state;
    next_timing_err = timing_err & ~err_clr;
    next_cke_err = cke_err & ~err_clr;
    rd_gap = 8'h00;
    if (exit_apd) begin
      // Exit timing follows the mode bit captured at the last mode set
      rd_gap = slow_exit ? (HIGH_GRADE ? dct_pkg::XARDS_HI : dct_pkg::XARDS_LO) - {5'h00, al}
                         : dct_pkg::XARD_CK;
    end
    if (off_wait != 8'h00) begin
      next_off_wait = off_wait - 8'h01;
      if (off_wait == 8'h01) begin
        next_term_on = 1'b0;
      end
    end
    if (fall && off_falls != 2'h0) begin
      next_off_falls = off_falls - 2'h1;
      if (off_falls == 2'h1) begin
        // Half of the last measured period, so a slowed clock stretches it too
        next_off_wait = (per_len >> 1) == 8'h00 ? 8'h01 : per_len >> 1;
      end
    end
    if (rise) begin
      // Period is remeasured every cycle, so a new frequency is simply picked up
      next_per_len = per_cnt + 8'h01;
      next_per_cnt = 8'h00;
      // Spacing is judged in registered edges, never in elapsed time
      if (since_rd != 8'hFF) next_since_rd = since_rd + 8'h01;
      if (since_wr != 8'hFF) next_since_wr = since_wr + 8'h01;
      if (since_act != 8'hFF) next_since_act = since_act + 8'h01;
      if (since_exit != 8'hFF) next_since_exit = since_exit + 8'h01;
      next_cke_r = s_cke;
      if (s_cke != cke_r) begin
        next_cke_run = 2'h1;
        // Level must have stood for three registrations before flipping
        if ({6'h00, cke_run} < dct_pkg::CKE_MIN_CK) next_cke_err = 1'b1;
        if (!s_cke) begin
          if (s_cmd == dct_pkg::LC_REF) next_pwr = dct_pkg::PS_SREF;
          else next_pwr = bank_open ? dct_pkg::PS_APD : dct_pkg::PS_PPD;
        end else begin
          next_pwr = dct_pkg::PS_RUN;
          next_exit_apd = (pwr_state == dct_pkg::PS_APD);
          // Start at one so each count is the distance in registrations
          next_since_exit = 8'h01;
        end
      end else if (cke_run != 2'h3) begin
        next_cke_run = cke_run + 2'h1;
      end
      if (s_cke && cke_r) begin
        case (s_cmd)
          dct_pkg::LC_ACT: begin
            if (since_exit < xp) next_timing_err = 1'b1;
            next_bank_open = 1'b1;
            next_since_act = 8'h01;
          end
          dct_pkg::LC_RD: begin
            if (since_wr < dct_pkg::WTR_CK) next_timing_err = 1'b1;
            if (since_exit < rd_gap) next_timing_err = 1'b1;
            next_since_rd = 8'h01;
          end
          dct_pkg::LC_WR, dct_pkg::LC_WRA: begin
            // No upper bound on the write strobe tail is imposed here
            next_since_wr = 8'h01;
            if (s_cmd == dct_pkg::LC_WRA) next_bank_open = 1'b0;
          end
          dct_pkg::LC_PRE: begin
            if (since_rd < {5'h00, al} + (bl8 ? 8'h04 : 8'h02)) next_timing_err = 1'b1;
            next_bank_open = 1'b0;
          end
          dct_pkg::LC_MRS: begin
            next_slow_exit = s_addr[dct_pkg::MR_SLOW];
            next_single_strobe = s_addr[dct_pkg::MR_STROBE];
            next_al = s_addr[dct_pkg::MR_AL_LSB +: 3];
            next_bl8 = s_addr[dct_pkg::MR_BL8];
          end
          default: begin
          end
        endcase
      end
      next_odt_r = s_odt;
      if (s_odt && !odt_r) begin
        next_on_cnt = dct_pkg::AOND_CK;
        next_off_falls = 2'h0;
        next_off_wait = 8'h00;
      end else if (!s_odt && odt_r) begin
        next_off_falls = dct_pkg::AOFD_FALLS;
        next_on_cnt = 2'h0;
      end else if (on_cnt != 2'h0) begin
        next_on_cnt = on_cnt - 2'h1;
        if (on_cnt == 2'h1) next_term_on = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cke_r <= 1'b0;
      odt_r <= 1'b0;
      bank_open <= 1'b0;
      exit_apd <= 1'b0;
      single_strobe <= 1'b0;
      bl8 <= 1'b0;
      al <= 3'h0;
      cke_run <= 2'h3;
      on_cnt <= 2'h0;
      off_falls <= 2'h0;
      per_cnt <= 8'h00;
      per_len <= 8'h00;
      off_wait <= 8'h00;
      since_rd <= 8'hFF;
      since_wr <= 8'hFF;
      since_act <= 8'hFF;
      since_exit <= 8'hFF;
      term_on <= 1'b0;
      slow_exit <= 1'b0;
      pwr_state <= dct_pkg::PS_PPD;
      timing_err <= 1'b0;
      cke_err <= 1'b0;
      diff_strobe <= 1'b1;
    end else if (ce) begin
      cke_r <= next_cke_r;
      odt_r <= next_odt_r;
      bank_open <= next_bank_open;
      exit_apd <= next_exit_apd;
      single_strobe <= next_single_strobe;
      bl8 <= next_bl8;
      al <= next_al;
      cke_run <= next_cke_run;
      on_cnt <= next_on_cnt;
      off_falls <= next_off_falls;
      per_cnt <= next_per_cnt;
      per_len <= next_per_len;
      off_wait <= next_off_wait;
      since_rd <= next_since_rd;
      since_wr <= next_since_wr;
      since_act <= next_since_act;
      since_exit <= next_since_exit;
      term_on <= next_term_on;
      slow_exit <= next_slow_exit;
      pwr_state <= next_pwr;
      timing_err <= next_timing_err;
      cke_err <= next_cke_err;
      diff_strobe <= ~next_single_strobe;
    end
  end
endmodule

// [hdl/dct_pkg.sv]
// Shared constants and types for both ends of the command timing link.
// Assumes a 200 MHz system clock on both ends.
package dct_pkg;
  localparam int CLK_PS = 5000;
  // Analog times in ns; cycle counts derived at run time from the link period, except TREFI_CYC, fixed at elaboration in system clock cycles
  localparam int TRP_NS = 15;
  localparam int ACT_TO_PRE_MIN_NS = 45;
  localparam int READ_TO_PRE_GAP_NS = 8;
  localparam int TREFI_NS = 7800;
  localparam int TREFI_CYC = TREFI_NS * 1000 / CLK_PS;
  // Counts in link clock cycles
  localparam logic [7:0] WTR_CK = 8'h02;
  localparam logic [7:0] CKE_MIN_CK = 8'h03;
  localparam logic [7:0] XARD_CK = 8'h02;
  localparam logic [7:0] XARDS_LO = 8'h08;
  localparam logic [7:0] XARDS_HI = 8'h07;
  localparam logic [7:0] XP_LO = 8'h02;
  localparam logic [7:0] XP_HI = 8'h03;
  localparam logic [1:0] AOND_CK = 2'h2;
  localparam logic [1:0] AOFD_FALLS = 2'h2;
  // Mode word layout
  localparam int MR_BL8 = 2;
  localparam int MR_AL_LSB = 3;
  localparam int MR_WR_LSB = 6;
  localparam int MR_STROBE = 10;
  localparam int MR_SLOW = 12;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  // Register map
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int CTRL_DIV_LSB = 8;
  localparam int ST_LOST = 4;
  localparam int ST_UNTRUSTED = 5;
  localparam logic [7:0] DIV_RESET = 8'h05;
  localparam logic [7:0] DIV_MIN = 8'h02;

  typedef enum logic [2:0] {
    LC_NOP = 3'h0, LC_ACT = 3'h1, LC_RD = 3'h2, LC_WR = 3'h3,
    LC_PRE = 3'h4, LC_MRS = 3'h5, LC_WRA = 3'h6, LC_REF = 3'h7
  } dct_cmd_e;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_ACT = 4'h1, OP_RD = 4'h2, OP_WR = 4'h3,
    OP_PRE = 4'h4, OP_MRS = 4'h5, OP_WRA = 4'h6, OP_REF = 4'h7,
    OP_PDE = 4'h8, OP_PDX = 4'h9, OP_SRE = 4'hA, OP_SRX = 4'hB
  } dct_op_e;

  typedef enum logic [1:0] {
    PS_RUN = 2'h0, PS_APD = 2'h1, PS_PPD = 2'h2, PS_SREF = 2'h3
  } dct_pwr_e;

  function automatic logic [7:0] ns_to_ck(input int unsigned ns, input logic [7:0] half);
    int unsigned per_ps;
    int unsigned q;
    per_ps = 2 * CLK_PS * int'(half);
    q = (ns * 1000 + per_ps - 1) / per_ps;
    return 8'(q);
  endfunction
endpackage

// [sim/dct_asserts.sv]
// Checker on the link between the command issuer and the device.
// Assumes hclk samples the divided link clock; gaps are counted in ck rises.
module dct_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ck,
  input wire logic cke,
  input wire logic [2:0] cmd,
  input wire logic [15:0] addr,
  input wire logic on_die_termination
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic ck_q;
  logic [7:0] cke_gap;
  logic [7:0] wr_gap;
  logic [7:0] rd_gap;
  logic rise;
  assign rise = ck && !ck_q;
  // Gaps saturate so a long idle stretch never wraps into a false short gap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ck_q <= 1'b0;
      cke_gap <= 8'hFF;
      wr_gap <= 8'hFF;
      rd_gap <= 8'hFF;
    end else begin
      ck_q <= ck;
      if ($changed(cke)) cke_gap <= 8'h00;
      else if (rise && cke_gap != 8'hFF) cke_gap <= cke_gap + 8'h01;
      if (rise && cmd == dct_pkg::LC_WR) wr_gap <= 8'h01;
      else if (rise && wr_gap != 8'hFF) wr_gap <= wr_gap + 8'h01;
      if (rise && cmd == dct_pkg::LC_RD) rd_gap <= 8'h01;
      else if (rise && rd_gap != 8'hFF) rd_gap <= rd_gap + 8'h01;
    end
  end
  ck_half_a: assert property ($changed(ck) |=> $stable(ck))
    else $error("link clock half period too short");
  cmd_edge_a: assert property ($changed(cmd) |-> !ck)
    else $error("command changed while ck high");
  odt_edge_a: assert property (ck |-> $stable(on_die_termination))
    else $error("odt changed while ck high");
  cke_edge_a: assert property ($changed(cke) |-> !ck)
    else $error("cke changed while ck high");
  cke_hold_a: assert property ($changed(cke) |-> cke_gap >= 8'h03)
    else $error("cke held for fewer than three rises");
  wtr_gap_a: assert property (rise && cmd == dct_pkg::LC_RD |-> wr_gap >= 8'h02)
    else $error("read too soon after write");
  exit_rd_a: assert property (rise && cmd == dct_pkg::LC_RD |-> cke && cke_gap >= 8'h02)
    else $error("read too soon after power down exit");
  exit_act_a: assert property (rise && cmd == dct_pkg::LC_ACT |-> cke_gap >= 8'h02)
    else $error("activate too soon after power down exit");
  rtp_gap_a: assert property (rise && cmd == dct_pkg::LC_PRE |-> rd_gap >= 8'h02)
    else $error("precharge too soon after read");
endmodule

// [sim/ddr2_command_timing_rules_tb.sv]
// Bench joining both ends over the link; software side is an AHB-Lite master.
// Assumes the issuer is the only slave and reports through its own registers.
module ddr2_command_timing_rules_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  wire logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic term_on, diff_strobe, slow_exit, timing_err, cke_err;
  dct_pkg::dct_pwr_e pwr_state;
  logic [31:0] rd;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  // Each command is followed by the power state both ends must settle in
  localparam logic [3:0] OPS [14] = '{4'h9, 4'h1, 4'h3, 4'h2, 4'h4, 4'h8, 4'h9,
    4'h1, 4'h8, 4'h9, 4'h2, 4'h4, 4'hA, 4'hB};
  localparam logic [1:0] PWS [14] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0,
    2'h0, 2'h1, 2'h0, 2'h0, 2'h0, 2'h3, 2'h0};
  localparam logic [3:0] SLOW [6] = '{4'h1, 4'h8, 4'h9, 4'h2, 4'h4, 4'h7};
  assign hready = hreadyout;
  dct_link_if dct_link_if_inst ();
  // Short refresh interval so a lost refresh shows up within the run
  dct_ctl_end #(.REFI_CYC(50)) dct_ctl_end_inst (.hclk(hclk), .hresetn(hresetn),
    .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .link(dct_link_if_inst));
  dct_mem_end dct_mem_end_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
    .link(dct_link_if_inst), .err_clr(1'b0), .term_on(term_on), .pwr_state(pwr_state),
    .diff_strobe(diff_strobe), .slow_exit(slow_exit), .timing_err(timing_err),
    .cke_err(cke_err));
  dct_asserts dct_asserts_inst (.hclk(hclk), .hresetn(hresetn), .ck(dct_link_if_inst.ck),
    .cke(dct_link_if_inst.cke), .cmd(dct_link_if_inst.cmd), .addr(dct_link_if_inst.addr),
    .on_die_termination(dct_link_if_inst.on_die_termination));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  // Entered just after a rising edge; returns at the edge that ends the data phase
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // Second empty command waits until the first has gone out on the link
  task automatic issue(input logic [3:0] op);
    ahb(dct_pkg::REG_CMD, 1'b1, {28'h000_0000, op});
    ahb(dct_pkg::REG_CMD, 1'b1, 32'h0000_0000);
    ahb(dct_pkg::REG_CMD, 1'b1, 32'h0000_0000);
  endtask
  task automatic odt_step(input logic v, input int lo, input int hi);
    int n;
    n = 0;
    ahb(dct_pkg::REG_CTRL, 1'b1, {16'h0000, 8'h05, 7'h00, v});
    while (dct_link_if_inst.on_die_termination !== v) @(posedge hclk);
    while (term_on !== v && n < 60) begin
      @(posedge hclk);
      n++;
    end
    chk("term delay in range", 32'h0000_0001, {31'h0, n >= lo && n <= hi});
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      $display("FAIL run length expected finish seen hang");
      close_out();
    end
  end
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("dev reset", 32'h0000_000A, {27'h0, term_on, diff_strobe, slow_exit, pwr_state});
    ahb(dct_pkg::REG_STATUS, 1'b0, 32'h0000_0000);
    chk("status reset", 32'h0000_0004, rd);
    ahb(dct_pkg::REG_CTRL, 1'b0, 32'h0000_0000);
    chk("ctrl reset", 32'h0000_0500, rd);
    ahb(8'h10, 1'b1, 32'hFFFF_FFFF);
    ahb(8'h10, 1'b0, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    for (int i = 0; i < 14; i++) begin
      issue(OPS[i]);
      ahb(dct_pkg::REG_STATUS, 1'b0, 32'h0000_0000);
      chk("issuer pwr", {30'h0, PWS[i]}, {30'h0, rd[2:1]});
      chk("device pwr", {30'h0, PWS[i]}, {30'h0, pwr_state});
    end
    ahb(dct_pkg::REG_MODE, 1'b1, 32'h0000_1400);
    issue(4'h5);
    chk("mode flags", 32'h0000_0001, {30'h0, diff_strobe, slow_exit});
    for (int i = 0; i < 6; i++) issue(SLOW[i]);
    chk("device errors", 32'h0000_0000, {30'h0, timing_err, cke_err});
    ahb(dct_pkg::REG_STATUS, 1'b0, 32'h0000_0000);
    chk("refresh lost", 32'h0000_0003, {30'h0, rd[5:4]});
    ahb(dct_pkg::REG_STATUS, 1'b1, 32'h0000_0030);
    ahb(dct_pkg::REG_STATUS, 1'b0, 32'h0000_0000);
    chk("refresh cleared", 32'h0000_0000, {30'h0, rd[5:4]});
    odt_step(1'b1, 27, 30);
    odt_step(1'b0, 26, 31);
    close_out();
  end
endmodule
